/* core/pdmc_pkg.sv */
/*
 * Shared constants and types of the power-down mode controller:
 * register byte addresses, field positions, reset values, mode codes,
 * wake source numbering and the stabilisation timing figures.
 * Assumes a 125 MHz reference clock and a 12-bit APB byte address.
 */
package pdmc_pkg;

    // APB address width and data width.
    localparam int APB_AW = 12;
    localparam int APB_DW = 32;

    // Printed index of the power mode register; its byte address is four times it.
    localparam logic [APB_AW-1:0] PMS_IDX = 12'h087;
    localparam logic [APB_AW-1:0] ADDR_PMS = {PMS_IDX[APB_AW-3:0], 2'b00};
    localparam logic [APB_AW-1:0] ADDR_SCC = 12'h300;
    localparam logic [APB_AW-1:0] ADDR_IEN = 12'h304;
    localparam logic [APB_AW-1:0] ADDR_STAB = 12'h308;
    localparam logic [APB_AW-1:0] ADDR_PCFG = 12'h30c;
    localparam logic [APB_AW-1:0] ADDR_STAT = 12'h310;

    // Mode codes of the power mode register and reset values.
    localparam logic [7:0] PMS_RST = 8'h00;
    localparam logic [7:0] CODE_IDLE = 8'h01;
    localparam logic [7:0] CODE_STOP = 8'h03;
    localparam logic [7:0] SCC_RST = 8'h00;
    localparam logic [31:0] IEN_RST = 32'h00000000;
    localparam logic [2:0] PCFG_RST = 3'h0;

    // Field positions.
    localparam int SCC_RC_BIT = 7;
    localparam int IEN_GLOBAL_BIT = 31;
    localparam int PCFG_EVC_BIT = 0;
    localparam int PCFG_SER_EXT_BIT = 1;
    localparam int PCFG_WATCH_SUB_BIT = 2;

    // Wake sources, one request line each.
    localparam int NWAKE = 9;
    localparam int W_EVC0 = 0;
    localparam int W_EVC2 = 1;
    localparam int W_SER = 2;
    localparam int W_EXT = 3;
    localparam int W_UART = 4;
    localparam int W_I2C = 5;
    localparam int W_WATCH = 6;
    localparam int W_WDOG = 7;
    localparam int W_BIT = 8;
    localparam logic [NWAKE-1:0] STOP_BASE_MASK = 9'h07f;
    localparam logic [NWAKE-1:0] STOP_RC_MASK = 9'h180;

    // Stabilisation timing: least wait in microseconds and clock rate in MHz.
    localparam int CLK_MHZ = 125;
    localparam int STAB_MIN_US = 20000;
    localparam int STAB_MIN_CYC = STAB_MIN_US * CLK_MHZ;
    localparam int BIT_DIV_DEF = 256;
    localparam int STAB_W = 16;

    // Controller states.
    typedef enum logic [1:0] {ST_RUN, ST_IDLE, ST_STOP, ST_STAB} pdmc_state_t;

    // Timer ticks that cover a wait of cyc clock cycles, rounded up.
    function automatic logic [STAB_W-1:0] stab_ticks(input int cyc, input int div);
        int t;
        t = (cyc + div - 1) / div;
        return STAB_W'(t);
    endfunction

    // One-hot of the lowest set bit of a wake vector.
    function automatic logic [NWAKE-1:0] first_hit(input logic [NWAKE-1:0] v);
        logic [NWAKE-1:0] r;
        r = '0;
        for (int i = NWAKE - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = '0;
                r[i] = 1'b1;
            end
        end
        return r;
    endfunction

endpackage

/* core/pdmc_stab_timer.sv */
/*
 * Stabilisation down-counter paced by the interval timer tick.
 * Assumes start, tick and load come from logic on the same clock.
 */
`timescale 1ns/100ps
module pdmc_stab_timer
    import pdmc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic tick_i,
    input wire logic [STAB_W-1:0] load_i,
    output logic busy_o,
    output logic done_o
);

    logic [STAB_W-1:0] cnt_ff;
    logic [STAB_W-1:0] nxt_cnt;
    logic busy_ff;
    logic nxt_busy;
    logic done_ff;
    logic nxt_done;

    // Loads on start, then counts ticks down and pulses done on the last one.
    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_busy = busy_ff;
        nxt_done = 1'b0;
        if (start_i) begin
            nxt_cnt = load_i;
            nxt_busy = 1'b1;
        end else if (busy_ff && tick_i) begin
            if (cnt_ff <= STAB_W'(1)) begin
                nxt_cnt = '0;
                nxt_busy = 1'b0;
                nxt_done = 1'b1;
            end else begin
                nxt_cnt = cnt_ff - STAB_W'(1);
            end
        end
    end

    // Registers the counter state.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff <= '0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            busy_ff <= nxt_busy;
            done_ff <= nxt_done;
        end
    end

    assign busy_o = busy_ff;
    assign done_o = done_ff;

endmodule

/* core/pdmc_ctrl.sv */
/*
 * Power-down mode controller: APB register file, idle and stop mode
 * sequencing, clock and peripheral run gates, wake qualification and
 * the oscillator stabilisation wait on wake from stop.
 * Assumes wake requests come from logic on REF_CLK_I, and that the APB
 * master keeps a request steady until PREADY is seen.
 */
// Our own choice: the APB slave port.
`timescale 1ns/100ps
module pdmc_ctrl
    import pdmc_pkg::*;
#(
    parameter int STAB_MIN_CYCLES = STAB_MIN_CYC,
    parameter int BIT_DIV = BIT_DIV_DEF
) (
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [APB_AW-1:0] PADDR_I,
    input wire logic [APB_DW-1:0] PWDATA_I,
    output logic [APB_DW-1:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic [NWAKE-1:0] WAKE_REQ_I,
    output logic CPU_RUN_O,
    output logic MAIN_OSC_EN_O,
    output logic SYS_CLK_EN_O,
    output logic PERIPH_CLK_EN_O,
    output logic RC_OSC_EN_O,
    output logic BIT_RUN_O,
    output logic WDOG_RUN_O,
    output logic WATCH_RUN_O,
    output logic TIMER_RUN_O,
    output logic SERIAL_RUN_O,
    output logic [NWAKE-1:0] IRQ_GRANT_O
);

    localparam logic [STAB_W-1:0] STAB_RST = stab_ticks(STAB_MIN_CYCLES, BIT_DIV);
    localparam logic [15:0] DIV_LAST = 16'(BIT_DIV - 1);

    pdmc_state_t state_ff;
    pdmc_state_t nxt_state;
    logic [7:0] pms_ff;
    logic [7:0] nxt_pms;
    logic [7:0] scc_ff;
    logic [7:0] nxt_scc;
    logic [31:0] ien_ff;
    logic [31:0] nxt_ien;
    logic [STAB_W-1:0] stab_ff;
    logic [STAB_W-1:0] nxt_stab;
    logic [2:0] pcfg_ff;
    logic [2:0] nxt_pcfg;
    logic rc_keep_ff;
    logic nxt_rc_keep;
    logic [NWAKE-1:0] pend_ff;
    logic [NWAKE-1:0] nxt_pend;
    logic [NWAKE-1:0] grant_ff;
    logic [NWAKE-1:0] nxt_grant;
    logic [APB_DW-1:0] rdata_ff;
    logic [APB_DW-1:0] nxt_rdata;
    logic slverr_ff;
    logic nxt_slverr;
    logic [15:0] div_ff;
    logic [15:0] nxt_div;
    logic bit_tick;
    logic apb_wr;
    logic reg_wr;
    logic apb_setup;
    logic pms_wr;
    logic addr_ok;
    logic stop_like;
    logic [NWAKE-1:0] allowed;
    logic [NWAKE-1:0] hit_vec;
    logic wake_hit;
    logic stab_start;
    logic stab_done;
    logic stab_busy;

    // APB strobes; the slave has no wait states.
    assign apb_setup = PSEL_I && !PENABLE_I;
    assign apb_wr = PSEL_I && PENABLE_I && PWRITE_I;
    // Control registers refuse writes while stopped so their contents survive the sleep.
    assign reg_wr = apb_wr && !stop_like;
    assign pms_wr = apb_wr && (PADDR_I == ADDR_PMS);
    assign addr_ok = (PADDR_I == ADDR_PMS) || (PADDR_I == ADDR_SCC) || (PADDR_I == ADDR_IEN)
        || (PADDR_I == ADDR_STAB) || (PADDR_I == ADDR_PCFG) || (PADDR_I == ADDR_STAT);

    // Wake sources that each mode may accept.
    always_comb begin
        allowed = '1;
        if (state_ff == ST_STOP) begin
            allowed = STOP_BASE_MASK;
            allowed[W_SER] = pcfg_ff[PCFG_SER_EXT_BIT];
            allowed[W_WATCH] = pcfg_ff[PCFG_WATCH_SUB_BIT];
            if (rc_keep_ff) begin
                allowed = allowed | STOP_RC_MASK;
            end
        end
    end

    // Only individually enabled requests under the global enable wake the device.
    assign hit_vec = WAKE_REQ_I & ien_ff[NWAKE-1:0] & allowed;
    assign wake_hit = ien_ff[IEN_GLOBAL_BIT] && (|hit_vec);

    // Mode sequencing; the register file holds in stop and the stabilisation wait, except the mode register clear on wake from stop.
    always_comb begin
        nxt_state = state_ff;
        nxt_rc_keep = rc_keep_ff;
        nxt_pend = pend_ff;
        nxt_grant = '0;
        stab_start = 1'b0;
        unique case (state_ff)
            ST_RUN: begin
                if (pms_wr && PWDATA_I[7:0] == CODE_IDLE) begin
                    nxt_state = ST_IDLE;
                end else if (pms_wr && PWDATA_I[7:0] == CODE_STOP) begin
                    nxt_state = ST_STOP;
                    nxt_rc_keep = scc_ff[SCC_RC_BIT];
                end
            end
            ST_IDLE: begin
                if (wake_hit) begin
                    nxt_state = ST_RUN;
                    nxt_grant = first_hit(hit_vec);
                end
            end
            ST_STOP: begin
                if (wake_hit) begin
                    nxt_state = ST_STAB;
                    nxt_pend = first_hit(hit_vec);
                    stab_start = 1'b1;
                end
            end
            ST_STAB: begin
                if (stab_done) begin
                    nxt_state = ST_RUN;
                    nxt_grant = pend_ff;
                    nxt_pend = '0;
                end
            end
        endcase
    end

    // Register writes, the automatic clear of the mode register and read data.
    always_comb begin
        nxt_pms = pms_ff;
        nxt_scc = scc_ff;
        nxt_ien = ien_ff;
        nxt_stab = stab_ff;
        nxt_pcfg = pcfg_ff;
        nxt_rdata = rdata_ff;
        nxt_slverr = 1'b0;
        if (pms_wr && state_ff == ST_RUN) begin
            nxt_pms = PWDATA_I[7:0];
        end
        if ((state_ff == ST_STOP || state_ff == ST_IDLE) && wake_hit) begin
            nxt_pms = PMS_RST;
        end
        if (reg_wr && PADDR_I == ADDR_SCC) begin
            nxt_scc = PWDATA_I[7:0];
        end
        if (reg_wr && PADDR_I == ADDR_IEN) begin
            nxt_ien = PWDATA_I;
        end
        if (reg_wr && PADDR_I == ADDR_STAB) begin
            nxt_stab = PWDATA_I[STAB_W-1:0];
        end
        if (reg_wr && PADDR_I == ADDR_PCFG) begin
            nxt_pcfg = PWDATA_I[2:0];
        end
        if (apb_setup) begin
            nxt_slverr = !addr_ok;
            nxt_rdata = '0;
            if (PADDR_I == ADDR_PMS) begin
                nxt_rdata = {24'h000000, pms_ff};
            end else if (PADDR_I == ADDR_SCC) begin
                nxt_rdata = {24'h000000, scc_ff};
            end else if (PADDR_I == ADDR_IEN) begin
                nxt_rdata = ien_ff;
            end else if (PADDR_I == ADDR_STAB) begin
                nxt_rdata = {16'h0000, stab_ff};
            end else if (PADDR_I == ADDR_PCFG) begin
                nxt_rdata = {29'h00000000, pcfg_ff};
            end else if (PADDR_I == ADDR_STAT) begin
                nxt_rdata = {16'h0000, 3'h0, stab_busy, pend_ff, rc_keep_ff, state_ff};
            end
        end
    end

    // Interval timer prescaler; it stops only in the RC-off stop variant.
    always_comb begin
        nxt_div = div_ff;
        bit_tick = 1'b0;
        if (BIT_RUN_O) begin
            if (div_ff >= DIV_LAST) begin
                nxt_div = '0;
                bit_tick = 1'b1;
            end else begin
                nxt_div = div_ff + 16'h0001;
            end
        end
    end

    // All state registers; a synchronous reset restores every reset value.
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            state_ff <= ST_RUN;
            pms_ff <= PMS_RST;
            scc_ff <= SCC_RST;
            ien_ff <= IEN_RST;
            stab_ff <= STAB_RST;
            pcfg_ff <= PCFG_RST;
            rc_keep_ff <= 1'b0;
            pend_ff <= '0;
            grant_ff <= '0;
            rdata_ff <= '0;
            slverr_ff <= 1'b0;
            div_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            pms_ff <= nxt_pms;
            scc_ff <= nxt_scc;
            ien_ff <= nxt_ien;
            stab_ff <= nxt_stab;
            pcfg_ff <= nxt_pcfg;
            rc_keep_ff <= nxt_rc_keep;
            pend_ff <= nxt_pend;
            grant_ff <= nxt_grant;
            rdata_ff <= nxt_rdata;
            slverr_ff <= nxt_slverr;
            div_ff <= nxt_div;
        end
    end

    // Stabilisation wait counted in interval timer ticks.
    pdmc_stab_timer u_stab (
        .clk_i(REF_CLK_I),
        .rst_i(RST_I),
        .start_i(stab_start),
        .tick_i(bit_tick),
        .load_i(stab_ff),
        .busy_o(stab_busy),
        .done_o(stab_done)
    );

    // Clock and peripheral gates decoded from the mode.
    assign stop_like = (state_ff == ST_STOP) || (state_ff == ST_STAB);
    assign CPU_RUN_O = (state_ff == ST_RUN);
    assign MAIN_OSC_EN_O = (state_ff != ST_STOP);
    assign SYS_CLK_EN_O = !stop_like;
    assign PERIPH_CLK_EN_O = !stop_like;
    assign RC_OSC_EN_O = !(state_ff == ST_STOP && !rc_keep_ff);
    assign BIT_RUN_O = !(state_ff == ST_STOP && !rc_keep_ff);
    assign WDOG_RUN_O = !(state_ff == ST_STOP && !rc_keep_ff);
    assign WATCH_RUN_O = !stop_like || pcfg_ff[PCFG_WATCH_SUB_BIT];
    assign TIMER_RUN_O = !stop_like || pcfg_ff[PCFG_EVC_BIT];
    assign SERIAL_RUN_O = !stop_like || pcfg_ff[PCFG_SER_EXT_BIT];
    assign IRQ_GRANT_O = grant_ff;
    assign PRDATA_O = rdata_ff;
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = slverr_ff && PSEL_I && PENABLE_I;

    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);

    a_idle_entry: assert property (pms_wr && state_ff == ST_RUN && PWDATA_I[7:0] == CODE_IDLE
        |=> state_ff == ST_IDLE && !CPU_RUN_O && SYS_CLK_EN_O && MAIN_OSC_EN_O)
        else $error("Idle code did not enter idle with clocks running.");
    a_stop_entry: assert property (pms_wr && state_ff == ST_RUN && PWDATA_I[7:0] == CODE_STOP
        |=> state_ff == ST_STOP && rc_keep_ff == $past(scc_ff[SCC_RC_BIT]))
        else $error("Stop code did not enter the selected stop variant.");
    a_stop_gates: assert property (state_ff == ST_STOP
        |-> !MAIN_OSC_EN_O && !SYS_CLK_EN_O && !PERIPH_CLK_EN_O && !CPU_RUN_O)
        else $error("A clock stayed on in stop mode.");
    a_rc_variant: assert property (state_ff == ST_STOP
        |-> RC_OSC_EN_O == rc_keep_ff && WDOG_RUN_O == rc_keep_ff)
        else $error("RC oscillator state does not match the stop variant.");
    a_pms_clear: assert property (state_ff == ST_STOP && wake_hit
        |=> pms_ff == PMS_RST ##1 state_ff == ST_STAB)
        else $error("Mode register not cleared on wake from stop.");
    a_stab_hold: assert property (state_ff == ST_STOP && wake_hit
        |=> !CPU_RUN_O throughout (state_ff == ST_STAB)[*2])
        else $error("CPU resumed before the stabilisation wait.");
    a_wake_gate: assert property (state_ff == ST_STOP && !ien_ff[IEN_GLOBAL_BIT]
        |=> state_ff == ST_STOP)
        else $error("Stop left without the global interrupt enable.");
    a_grant_src: assert property (state_ff == ST_STAB && stab_done
        |=> IRQ_GRANT_O == $past(pend_ff) && CPU_RUN_O)
        else $error("Wrong service grant after the stabilisation wait.");
    a_regs_held: assert property (state_ff == ST_STOP && !wake_hit
        |=> $stable(scc_ff) && $stable(ien_ff) && $stable(pms_ff))
        else $error("Control register changed during stop.");
    a_timer_gate: assert property (stop_like
        |-> TIMER_RUN_O == pcfg_ff[PCFG_EVC_BIT] && SERIAL_RUN_O == pcfg_ff[PCFG_SER_EXT_BIT])
        else $error("Timer or serial gate wrong in stop.");
    a_bad_code: assert property (pms_wr && state_ff == ST_RUN && PWDATA_I[7:0] != CODE_IDLE
        && PWDATA_I[7:0] != CODE_STOP |=> state_ff == ST_RUN && CPU_RUN_O)
        else $error("Unknown code entered a low-power mode.");

    c_idle_wake: cover property (state_ff == ST_IDLE ##1 state_ff == ST_RUN);
    c_stop_rc_on: cover property (state_ff == ST_STOP && rc_keep_ff ##1 state_ff == ST_STAB);
    c_stop_rc_off: cover property (state_ff == ST_STOP && !rc_keep_ff ##1 state_ff == ST_STAB);
    c_stab_done: cover property (state_ff == ST_STAB ##1 state_ff == ST_RUN);

endmodule

/* tb/power_down_mode_controller_test.sv */
/*
 * Self-checking testbench of the power-down mode controller: mode codes
 * from a table, reset values, unmapped access, idle and stop wake-up.
 * Assumes the controller answers APB with no wait states and is built with
 * a short stabilisation prescaler so that each wait stays brief.
 */
`timescale 1ns/100ps
module power_down_mode_controller_test;
    import pdmc_pkg::*;

    localparam int TB_DIV = 4;
    localparam int TB_MIN = 40;

    logic clk;
    logic rst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_AW-1:0] paddr;
    logic [APB_DW-1:0] pwdata;
    logic [APB_DW-1:0] prdata;
    logic pready;
    logic pslverr;
    logic [NWAKE-1:0] wake;
    logic [NWAKE-1:0] grant;
    logic cpu_run, main_en, sys_en, per_en, rc_en, bit_run, wdog_run, watch_run, tmr_run, ser_run;
    logic [9:0] gates;
    logic [31:0] rd;
    logic err;
    logic [25:0] rows [6];
    int fails;
    int checks_done;

    // Run gates gathered into one vector, CPU first.
    assign gates = {cpu_run, main_en, sys_en, per_en, rc_en, bit_run, wdog_run, watch_run,
                    tmr_run, ser_run};

    pdmc_ctrl #(.STAB_MIN_CYCLES(TB_MIN), .BIT_DIV(TB_DIV)) dut (
        .REF_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .WAKE_REQ_I(wake), .CPU_RUN_O(cpu_run),
        .MAIN_OSC_EN_O(main_en), .SYS_CLK_EN_O(sys_en), .PERIPH_CLK_EN_O(per_en),
        .RC_OSC_EN_O(rc_en), .BIT_RUN_O(bit_run), .WDOG_RUN_O(wdog_run), .WATCH_RUN_O(watch_run),
        .TIMER_RUN_O(tmr_run), .SERIAL_RUN_O(ser_run), .IRQ_GRANT_O(grant)
    );

    // Clock of 8 ns period.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Compares a seen value with the expected one and counts the result.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // One APB transfer; returns at the edge where pready was taken.
    task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk({31'h0, pready}, 32'h1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Holds reset for four cycles, then lets one edge pass.
    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask

    // Enters stop, shows refused wakes, wakes by a good source, checks resume.
    task automatic stop_run(input logic [7:0] scc, input logic [31:0] ien,
                            input logic [2:0] cfg, input logic [9:0] g,
                            input logic [8:0] bad, input logic [8:0] good);
        int n;
        apb(1'b1, ADDR_SCC, {24'h0, scc}, rd);
        apb(1'b1, ADDR_IEN, ien, rd);
        apb(1'b1, ADDR_PCFG, {29'h0, cfg}, rd);
        apb(1'b1, ADDR_STAB, 32'h3, rd);
        apb(1'b1, ADDR_PMS, 32'h3, rd);
        #1 chk(gates, g);
        apb(1'b1, ADDR_SCC, {24'h0, ~scc}, rd);
        @(posedge clk);
        wake <= bad;
        repeat (3) @(posedge clk);
        #1 chk(gates, g);
        @(posedge clk);
        wake <= bad | good;
        @(posedge clk);
        #1 chk({cpu_run, main_en, sys_en}, 3'b010);
        @(posedge clk);
        wake <= '0;
        n = 0;
        while (cpu_run !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1 n++;
        end
        chk(grant, good);
        chk(n >= 8 && n <= 14, 1'b1);
        apb(1'b0, ADDR_PMS, 32'h0, rd);
        chk(rd, 32'h0);
        apb(1'b0, ADDR_SCC, 32'h0, rd);
        chk(rd, {24'h0, scc});
    endtask

    // Stops a hung run.
    initial begin
        #160000;
        fails++;
        wrap_up();
    end

    // Main sequence: table of mode codes, then hand-written cases.
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        wake = '0;
        fails = 0;
        checks_done = 0;
        err = 1'b0;
        rows[0] = {8'h01, 8'h00, 10'h1ff};
        rows[1] = {8'h03, 8'h80, 10'h038};
        rows[2] = {8'h03, 8'h00, 10'h000};
        rows[3] = {8'h02, 8'h00, 10'h3ff};
        rows[4] = {8'hff, 8'h80, 10'h3ff};
        rows[5] = {8'h00, 8'h00, 10'h3ff};
        do_reset();
        // Each row: code written, gates and stored code checked, then reset.
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, ADDR_SCC, {24'h0, rows[i][17:10]}, rd);
            apb(1'b1, ADDR_PMS, {24'h0, rows[i][25:18]}, rd);
            #1 chk(gates, rows[i][9:0]);
            apb(1'b0, ADDR_PMS, 32'h0, rd);
            chk(rd, {24'h0, rows[i][25:18]});
            do_reset();
            #1 chk(gates, 10'h3ff);
            apb(1'b0, ADDR_PMS, 32'h0, rd);
            chk(rd, 32'h0);
            $display("row %0d done", i);
        end
        // Reset values, a read-only status and an unmapped place.
        apb(1'b0, ADDR_STAB, 32'h0, rd);
        chk(rd, (TB_MIN + TB_DIV - 1) / TB_DIV);
        apb(1'b0, ADDR_IEN, 32'h0, rd);
        chk(rd, IEN_RST);
        apb(1'b1, ADDR_STAT, 32'hffffffff, rd);
        apb(1'b0, ADDR_STAT, 32'h0, rd);
        chk(rd[1:0], 2'h0);
        apb(1'b0, 12'h400, 32'h0, rd);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        $display("register test done");
        // Idle: a disabled source is ignored, the lowest enabled one is served.
        apb(1'b1, ADDR_IEN, 32'h80000028, rd);
        apb(1'b1, ADDR_PMS, 32'h1, rd);
        @(posedge clk);
        wake <= 9'h001;
        repeat (3) @(posedge clk);
        #1 chk(gates, 10'h1ff);
        @(posedge clk);
        wake <= 9'h029;
        @(posedge clk);
        #1 chk({cpu_run, grant}, {1'b1, 9'h008});
        @(posedge clk);
        wake <= '0;
        #1 chk(grant, 9'h000);
        $display("idle test done");
        // Stop with RC kept: serial wake refused, watchdog wake served.
        stop_run(8'h80, 32'h80000084, 3'b001, 10'h03a, 9'h004, 9'h080);
        $display("stop rc-on test done");
        // Stop with RC off: watchdog and interval wakes refused, watch wake served.
        stop_run(8'h00, 32'h800001c0, 3'b110, 10'h005, 9'h180, 9'h040);
        $display("stop rc-off test done");
        wrap_up();
    end

endmodule
